/* File: dbs_defs.svh */
// Constants shared by both ends of the probe link
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

// ----------------------------------------
// Link-side register map of the device end
// ----------------------------------------
`define DBS_REG_CTRL   2'h0
`define DBS_REG_STA    2'h1
`define DBS_REG_STB    2'h2
`define DBS_CTRL_ERASE 0
`define DBS_STA_DONE   0
`define DBS_STA_HOLD   1
`define DBS_STA_PROT_ERR 2
`define DBS_STA_BUSY   3
`define DBS_STB_PRES   0
`define DBS_STB_HPA    1

// ----------------------------------------
// Serial frame: start, rnw, addr[1:0], data[7:0]
// ----------------------------------------
`define DBS_FRAME_LAST 4'hB
`define DBS_HDR_LAST   4'h3
`define DBS_DATA_TOP   4'h7

// ----------------------------------------
// Probe controller map and timing
// ----------------------------------------
`define DBS_PRB_CMD    1'h0
`define DBS_PRB_STAT   1'h1
`define DBS_ACT_COLD   2'h0
`define DBS_ACT_RESTART 2'h1
`define DBS_ACT_WRITE  2'h2
`define DBS_ACT_READ   2'h3
`define DBS_SCK_HALF   8'h08
`define DBS_RST_HOLD   8'h40
`define DBS_SETTLE     8'h10

`endif

/* File: dbs_pkg.sv */
// Types shared by both ends of the probe link
package dbs_pkg;

  // ----------------------------------------
  // Device end
  // ----------------------------------------
  typedef enum logic [1:0] {
    ES_IDLE  = 2'b00,
    ES_VCLR  = 2'b01,
    ES_FLASH = 2'b10,
    ES_SEC   = 2'b11
  } dbs_erase_t;

  typedef struct packed {
    logic       rst_s1;
    logic       rst_s2;
    logic       rst_s3;
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_s3;
    logic       dio_s1;
    logic       dio_s2;
    logic       hold;
    logic       prot_err;
    logic       done;
    logic       present;
    logic       hp_off;
    dbs_erase_t st;
    logic [3:0] bitn;
    logic       rnw;
    logic [11:0] sh;
    logic [7:0] dsh;
    logic       dout;
    logic       doe;
  } dbs_dev_t;

  // ----------------------------------------
  // Probe end
  // ----------------------------------------
  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_RSTLO = 2'b01,
    PS_REL   = 2'b10,
    PS_SHIFT = 2'b11
  } dbs_pst_t;

  typedef struct packed {
    dbs_pst_t    st;
    logic [7:0]  cnt;
    logic [3:0]  bitn;
    logic [11:0] frame;
    logic [7:0]  rdat;
    logic        rnw;
    logic        sck;
    logic        sckoe;
    logic        rst_n;
    logic        dout;
    logic        doe;
    logic        dio_s1;
    logic        dio_s2;
    logic        wpend;
    logic        waddr;
    logic [31:0] hrdata;
  } dbs_prb_t;

endpackage

/* File: dbs_link_if.sv */
// Reset, clock and data wires between probe and device
`timescale 1ns/100ps
`default_nettype none
interface dbs_link_if;
  logic rst_n_o;
  logic rst_oe;
  logic sck_o;
  logic sck_oe;
  logic sck_pu;
  logic pdio_o;
  logic pdio_oe;
  logic ddio_o;
  logic ddio_oe;
  logic rst_n;
  logic sck;
  logic dio;

  // Wire levels: reset pulled high, clock held by pull-up, data weak low
  assign rst_n = rst_oe ? rst_n_o : 1'h1;
  assign sck   = sck_oe ? sck_o : sck_pu;
  assign dio   = pdio_oe ? pdio_o : (ddio_oe ? ddio_o : 1'h0);

  modport dev (
    input  rst_n, sck, dio,
    output sck_pu, ddio_o, ddio_oe
  );
  modport prb (
    input  dio,
    output rst_n_o, rst_oe, sck_o, sck_oe, pdio_o, pdio_oe
  );
endinterface
`default_nettype wire

/* File: dbs_dev.sv */
// Device end: probe detection, CPU reset hold and chip erase
//
// Summary of operation
// RULE1 - Reset release with clock low holds CPU
// RULE2 - Clock line pulled up from startup
// RULE3 - Hold flag set while CPU held
// RULE4 - Write one releases hold; zero ignored
// RULE5 - Protected: release refused, error flag set
// RULE6 - Cold plug requests CPU reset hold
// RULE7 - Hot-plug detector reset during any reset
// RULE8 - Clock falling edge detects hot plug
// RULE9 - Pad switched away disables hot plug
// RULE10 - Hot-plug availability shown in status B
// RULE11 - Any detection sets probe-present flag
// RULE12 - Protection disables hot plug
// RULE13 - Probe holds reset past power-on reset
// RULE14 - Erase clears RAM, flash, security; keeps aux
// RULE15 - Erase refused once erase lock set
// RULE16 - Erase trigger bit starts erase unless guarded
// RULE17 - Volatile clear finishes before flash erase
// RULE18 - Done flag set when erase completes
// RULE19 - Probe cold plugs, erases, polls, resets
// RULE20 - Programming allowed only when unprotected
// RULE21 - Probe programs after cold plug and erase
// RULE22 - Probe restarts with clock high
// RULE23 - Commands discarded while erase in progress
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_dev (
  input  wire logic hclk,
  input  wire logic hresetn,
  dbs_link_if.dev   link,
  input  wire logic secure_i,
  input  wire logic erase_lock_i,
  input  wire logic guard_wp_i,
  input  wire logic pad_debug_i,
  input  wire logic vclr_done_i,
  input  wire logic flash_done_i,
  output logic      sys_rst_n_o,
  output logic      cpu_rst_n_o,
  output logic      vclr_req_o,
  output logic      flash_req_o,
  output logic      sec_clear_o,
  output logic      prog_allow_o,
  output logic      cpu_reset_hold_flag,
  output logic      probe_present_flag,
  output logic      hot_plug_available
);

  dbs_pkg::dbs_dev_t q;
  dbs_pkg::dbs_dev_t d;

  logic       sck_rise;
  logic       sck_fall;
  logic       rst_rel;
  logic       busy;
  logic [11:0] nsh;
  logic [7:0] status_reg_a;
  logic [7:0] status_reg_b;

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  // Used at the read header and for nothing else yet, kept as one place
  function automatic logic [7:0] rd_reg(
    input logic [1:0] a,
    input logic [7:0] sa,
    input logic [7:0] sb
  );
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `DBS_REG_STA: r = sa;
      `DBS_REG_STB: r = sb;
      default:      r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Derived terms
  // ----------------------------------------
  // Edges taken from second and third stages only
  assign sck_rise = q.sck_s2 & ~q.sck_s3;
  assign sck_fall = ~q.sck_s2 & q.sck_s3;
  assign rst_rel  = q.rst_s2 & ~q.rst_s3;
  assign busy     = (q.st != dbs_pkg::ES_IDLE);
  assign nsh      = {q.sh[10:0], q.dio_s2};

  // Detector live only out of every reset, pad on debug, unprotected
  assign hot_plug_available = q.rst_s2 & ~q.hp_off & pad_debug_i
                              & ~secure_i; // [RULE7] [RULE9] [RULE12]

  always_comb begin
    status_reg_a = 8'h00;
    status_reg_a[`DBS_STA_DONE] = q.done;
    status_reg_a[`DBS_STA_HOLD] = q.hold;
    status_reg_a[`DBS_STA_PROT_ERR] = q.prot_err;
    status_reg_a[`DBS_STA_BUSY] = busy;
    status_reg_b = 8'h00;
    status_reg_b[`DBS_STB_PRES] = q.present;
    status_reg_b[`DBS_STB_HPA]  = hot_plug_available; // [RULE10]
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    d = q;
    // Pins from the probe pass two flops before use
    d.rst_s1 = link.rst_n;
    d.rst_s2 = q.rst_s1;
    d.rst_s3 = q.rst_s2;
    d.sck_s1 = link.sck;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.dio_s1 = link.dio;
    d.dio_s2 = q.dio_s1;

    // Pad loss latches off until the next reset
    if (!pad_debug_i && q.rst_s2) begin
      d.hp_off = 1'h1; // [RULE9]
    end

    // Cold plug: reset pin rises while clock still low
    if (rst_rel && !q.sck_s2) begin
      d.hold    = 1'h1; // [RULE1] [RULE3] [RULE6]
      d.present = 1'h1; // [RULE11]
    end

    // Hot plug: a falling clock edge outside reset
    if (sck_fall && hot_plug_available) begin
      d.present = 1'h1; // [RULE8] [RULE11]
    end

    // Serial frame receiver, clocked by sampled rising edges
    if (sck_rise) begin
      if (q.bitn == 4'h0) begin
        if (q.dio_s2) begin
          d.bitn = 4'h1;
          d.sh   = 12'h001;
        end
      end else begin
        d.sh   = nsh;
        d.bitn = q.bitn + 4'h1;
        if (q.bitn == 4'h1) begin
          d.rnw = q.dio_s2;
        end
        // Header complete: load read data for the data slots
        if (q.bitn == `DBS_HDR_LAST) begin
          d.dsh = rd_reg(nsh[1:0], status_reg_a, status_reg_b);
        end
        if (q.bitn == `DBS_FRAME_LAST) begin
          d.bitn = 4'h0;
          if (!q.rnw && !busy) begin // [RULE23]
            case (nsh[9:8])
              `DBS_REG_CTRL: begin
                if (nsh[`DBS_CTRL_ERASE] && !guard_wp_i
                    && !erase_lock_i) begin // [RULE15] [RULE16]
                  d.st   = dbs_pkg::ES_VCLR;
                  d.done = 1'h0;
                end
              end
              `DBS_REG_STA: begin
                if (nsh[`DBS_STA_HOLD]) begin // [RULE4]
                  if (secure_i) begin
                    d.prot_err = 1'h1; // [RULE5]
                  end else begin
                    d.hold = 1'h0; // [RULE4]
                  end
                end else if (nsh[`DBS_STA_PROT_ERR]) begin
                  d.prot_err = 1'h0;
                end
              end
              default: begin
                d.bitn = 4'h0;
              end
            endcase
          end
        end
      end
    end

    // Read data driven from each falling edge in the data slots
    if (sck_fall && q.rnw && q.bitn > `DBS_HDR_LAST) begin
      d.doe  = 1'h1;
      d.dout = q.dsh[7];
      d.dsh  = {q.dsh[6:0], 1'h0};
    end
    if (q.bitn == 4'h0) begin
      d.doe = 1'h0;
    end

    // Erase sequencer; volatile clear strictly first
    case (q.st)
      dbs_pkg::ES_IDLE: begin
        d.st = d.st;
      end
      dbs_pkg::ES_VCLR: begin
        if (vclr_done_i) begin
          d.st = dbs_pkg::ES_FLASH; // [RULE17]
        end
      end
      dbs_pkg::ES_FLASH: begin
        if (flash_done_i) begin
          d.st = dbs_pkg::ES_SEC;
        end
      end
      dbs_pkg::ES_SEC: begin
        d.st   = dbs_pkg::ES_IDLE;
        d.done = 1'h1; // [RULE18]
      end
      default: begin
        d.st = dbs_pkg::ES_IDLE;
      end
    endcase

    // Reset pin low: system in reset, detector and receiver cleared
    if (!q.rst_s2) begin
      d.hp_off = 1'h0; // [RULE7]
      d.bitn   = 4'h0;
      d.doe    = 1'h0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Clock stages start at the pulled-up idle level: no false edge
      q        <= '0;
      q.sck_s1 <= 1'h1;
      q.sck_s2 <= 1'h1;
      q.sck_s3 <= 1'h1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pull-up always on so a floating clock never looks like a probe
  assign link.sck_pu  = 1'h1; // [RULE2]
  assign link.ddio_o  = q.dout;
  assign link.ddio_oe = q.doe;

  // Rest of the system leaves reset; CPU stays while held
  assign sys_rst_n_o  = q.rst_s2;
  assign cpu_rst_n_o  = q.rst_s2 & ~q.hold; // [RULE1]
  assign cpu_reset_hold_flag = q.hold; // [RULE3]
  assign probe_present_flag  = q.present;

  // Flash request covers main array and data section, never aux rows
  assign vclr_req_o   = (q.st == dbs_pkg::ES_VCLR);
  assign flash_req_o  = (q.st == dbs_pkg::ES_FLASH); // [RULE14]
  assign sec_clear_o  = (q.st == dbs_pkg::ES_SEC); // [RULE14]
  assign prog_allow_o = ~secure_i; // [RULE20]

endmodule
`default_nettype wire

/* File: dbs_probe.sv */
// Probe end: AHB-Lite commanded reset, clock and frame driver
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_probe #(
  parameter logic [7:0] RST_HOLD = `DBS_RST_HOLD
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  dbs_link_if.prb          link
);

  dbs_pkg::dbs_prb_t q;
  dbs_pkg::dbs_prb_t d;
  logic              take;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  assign take = hsel & htrans[1] & hready;

  always_comb begin
    d = q;
    d.dio_s1 = link.dio;
    d.dio_s2 = q.dio_s1;
    d.wpend  = 1'h0;
    // Address phase: note writes, prepare read data at once
    if (take) begin
      d.wpend  = hwrite;
      d.waddr  = haddr[2];
      d.hrdata = 32'h0000_0000;
      if (haddr[2] == `DBS_PRB_STAT) begin
        d.hrdata = {16'h0000, q.rdat, 7'h00,
                    (q.st != dbs_pkg::PS_IDLE)};
      end
    end
    // Data phase write of a command; ignored while busy
    if (q.wpend && q.waddr == `DBS_PRB_CMD
        && q.st == dbs_pkg::PS_IDLE && hwdata[0]) begin
      d.cnt   = 8'h00;
      d.sckoe = 1'h1;
      case (hwdata[2:1])
        `DBS_ACT_COLD: begin
          d.st  = dbs_pkg::PS_RSTLO;
          d.sck = 1'h0; // [RULE21]
        end
        `DBS_ACT_RESTART: begin
          d.st  = dbs_pkg::PS_RSTLO;
          d.sck = 1'h1; // [RULE22]
        end
        default: begin
          d.st    = dbs_pkg::PS_SHIFT;
          d.rnw   = hwdata[2:1] == `DBS_ACT_READ;
          d.frame = {1'h1, d.rnw, hwdata[5:4], hwdata[15:8]};
          d.bitn  = `DBS_FRAME_LAST;
        end
      endcase
    end
    case (q.st)
      dbs_pkg::PS_IDLE: begin
        d.doe = 1'h0;
      end
      dbs_pkg::PS_RSTLO: begin
        // Held long enough to outlast power-on reset
        d.rst_n = 1'h0;
        d.cnt   = q.cnt + 8'h01;
        if (q.cnt == RST_HOLD) begin // [RULE13]
          d.st    = dbs_pkg::PS_REL;
          d.cnt   = 8'h00;
          d.rst_n = 1'h1;
        end
      end
      dbs_pkg::PS_REL: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == `DBS_SETTLE) begin
          d.st = dbs_pkg::PS_IDLE; // [RULE19]
        end
      end
      dbs_pkg::PS_SHIFT: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == 8'h00) begin
          d.sck  = 1'h0;
          d.dout = q.frame[q.bitn];
          d.doe  = ~(q.rnw && q.bitn <= `DBS_DATA_TOP);
        end
        // Sample returned bit just before the rising edge
        if (q.cnt == `DBS_SCK_HALF - 8'h01 && q.rnw
            && q.bitn <= `DBS_DATA_TOP) begin
          d.rdat = {q.rdat[6:0], q.dio_s2};
        end
        if (q.cnt == `DBS_SCK_HALF) begin
          d.sck = 1'h1;
        end
        if (q.cnt == (`DBS_SCK_HALF << 1) - 8'h01) begin
          d.cnt  = 8'h00;
          d.bitn = q.bitn - 4'h1;
          if (q.bitn == 4'h0) begin
            d.st  = dbs_pkg::PS_IDLE;
            d.doe = 1'h0;
          end
        end
      end
      default: begin
        d.st = dbs_pkg::PS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.rst_n <= 1'h1;
      q.sck   <= 1'h1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout    = 1'h1;
  assign hresp        = 1'h0;
  assign hrdata       = q.hrdata;
  assign link.rst_n_o = q.rst_n;
  assign link.rst_oe  = 1'h1;
  assign link.sck_o   = q.sck;
  assign link.sck_oe  = q.sckoe;
  assign link.pdio_o  = q.dout;
  assign link.pdio_oe = q.doe;

endmodule
`default_nettype wire

/* File: dbs_link_monitor.sv */
// Checker for the probe link and the device end
`timescale 1ns/100ps
`default_nettype none
module dbs_link_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic sck_pu,
  input wire logic secure_i,
  input wire logic erase_lock_i,
  input wire logic guard_wp_i,
  input wire logic pad_debug_i,
  input wire logic sys_rst_n_o,
  input wire logic cpu_rst_n_o,
  input wire logic vclr_req_o,
  input wire logic flash_req_o,
  input wire logic sec_clear_o,
  input wire logic prog_allow_o,
  input wire logic cpu_reset_hold_flag,
  input wire logic probe_present_flag,
  input wire logic hot_plug_available
);
  // ----------------------------------------
  // Device-end properties
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Pin high long enough that a pin reset cannot be in flight
  sequence s_pin_high;
    rst_n [*8];
  endsequence
  // Security clear is a lone pulse
  sequence s_sec_pulse;
    sec_clear_o ##1 !sec_clear_o;
  endsequence
  // Pin low for three samples: synchronised reset has landed
  sequence s_pin_low;
    !rst_n [*3];
  endsequence

  // Detection, hold and erase sequencing
  a_pull_up_on: assert property (
    sck_pu) else $error("clock pull-up not applied");
  a_cold_plug_hold: assert property (
    $rose(rst_n) && !sck |-> ##[1:6]
    (cpu_reset_hold_flag && probe_present_flag))
    else $error("cold plug not detected");
  a_hold_keeps_cpu: assert property (
    cpu_reset_hold_flag && $past(cpu_reset_hold_flag) |-> !cpu_rst_n_o)
    else $error("cpu ran while held");
  a_secure_refuse: assert property (
    s_pin_high ##0 ($past(cpu_reset_hold_flag) && $past(secure_i))
    |-> cpu_reset_hold_flag) else $error("protected hold released");
  a_hot_plug_seen: assert property (
    $fell(sck) && rst_n && sys_rst_n_o && hot_plug_available
    |-> ##[1:6] (probe_present_flag || !rst_n))
    else $error("hot plug missed");
  a_secure_no_hot: assert property (
    secure_i |-> !hot_plug_available) else $error("hot plug while protected");
  a_pad_off_hot: assert property (
    $past(!pad_debug_i) && $past(sys_rst_n_o) && sys_rst_n_o && rst_n
    |-> !hot_plug_available) else $error("hot plug with pad away");
  a_reset_no_hot: assert property (
    s_pin_low |-> !hot_plug_available)
    else $error("hot plug live in reset");
  a_vclr_then_flash: assert property (
    $rose(flash_req_o) |-> $past(vclr_req_o) && !vclr_req_o)
    else $error("flash erase before volatile clear");
  a_sec_after_flash: assert property (
    sec_clear_o |-> $past(flash_req_o) ##0 s_sec_pulse)
    else $error("security clear out of step");
  a_erase_gated: assert property (
    $rose(vclr_req_o) |-> !$past(erase_lock_i) && !$past(guard_wp_i))
    else $error("erase started while locked");
  a_prog_gate: assert property (
    prog_allow_o == !secure_i) else $error("programming gate wrong");
endmodule
`default_nettype wire

/* File: test_debug_probe_reset_and_erase.sv */
// Self-checking bench for the probe link, both ends
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.svh"
module test_debug_probe_reset_and_erase;
  logic        hclk, vclr_q = 1'h0, ack_en = 1'h1;
  logic        hresetn = 1'h0, secure_i = 1'h1, pad_debug_i = 1'h1;
  logic        erase_lock_i = 1'h0, guard_wp_i = 1'h0;
  logic        vclr_done_i = 1'h0, flash_done_i = 1'h0, hwrite = 1'h0;
  logic        sys_rst_n_o, cpu_rst_n_o, vclr_req_o, flash_req_o;
  logic        sec_clear_o, prog_allow_o, cpu_reset_hold_flag;
  logic        probe_present_flag, hot_plug_available, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  d;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rx, seed = 32'h58;
  int          miscompares, comparisons, vclr_rises;

  // ----------------------------------------
  // Both ends joined on one link
  // ----------------------------------------
  dbs_link_if link_if ();
  dbs_dev i_dbs_dev (
    .hclk, .hresetn, .link(link_if), .secure_i, .erase_lock_i,
    .guard_wp_i, .pad_debug_i, .vclr_done_i, .flash_done_i,
    .sys_rst_n_o, .cpu_rst_n_o, .vclr_req_o, .flash_req_o,
    .sec_clear_o, .prog_allow_o, .cpu_reset_hold_flag,
    .probe_present_flag, .hot_plug_available);
  // Short reset hold keeps the run brief
  dbs_probe #(.RST_HOLD(8'h08)) i_dbs_probe (
    .hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .link(link_if));
  dbs_link_monitor i_dbs_link_monitor (
    .hclk, .hresetn, .rst_n(link_if.rst_n), .sck(link_if.sck),
    .sck_pu(link_if.sck_pu), .secure_i, .erase_lock_i, .guard_wp_i,
    .pad_debug_i, .sys_rst_n_o, .cpu_rst_n_o, .vclr_req_o,
    .flash_req_o, .sec_clear_o, .prog_allow_o, .cpu_reset_hold_flag,
    .probe_present_flag, .hot_plug_available);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bus clock
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] sta(input logic dn, hd, pe, bz);
    return {4'h0, bz, pe, hd, dn};
  endfunction
  function logic [7:0] stb(input logic pr, hp);
    return {6'h0, hp, pr};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [31:0] a, wd,
                      output logic [31:0] r);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  // Probe action, then poll busy until clear
  task automatic op(input logic [1:0] act, ra, input logic [7:0] wd);
    logic [31:0] r;
    xfer(1'h1, 32'h0, {16'h0, wd, 2'h0, ra, 1'h0, act, 1'h1}, r);
    do xfer(1'h0, 32'h4, 32'h0, r); while (r[0] !== 1'h0);
    d = r[15:8];
  endtask
  task automatic wr(input logic [1:0] ra, input logic [7:0] wd);
    op(`DBS_ACT_WRITE, ra, wd);
  endtask
  task automatic rd(input logic [1:0] ra);
    op(`DBS_ACT_READ, ra, 8'h00);
  endtask

  // Memory and flash acks at random delay; security clear pulse clears security
  always @(posedge hclk) begin
    rx = xs();
    vclr_done_i  <= vclr_req_o & ack_en & rx[0];
    flash_done_i <= flash_req_o & ack_en & rx[1];
    vclr_q       <= vclr_req_o;
    if (vclr_req_o & ~vclr_q)
      vclr_rises++;
    if (sec_clear_o)
      secure_i <= 1'h0;
  end

  // Cuts a hung handshake short
  initial begin
    #2000000;
    miscompares++;
    print_verdict;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (4) @(posedge hclk);
    chk("clock idle", link_if.sck, 1'h1);
    chk("prog gate", prog_allow_o, 1'h0);
    rd(`DBS_REG_STB);
    chk("stb guarded", d, stb(1'h0, 1'h0));
    // Cold plug on a protected part
    op(`DBS_ACT_COLD, 2'h0, 8'h00);
    chk("hold flag", cpu_reset_hold_flag, 1'h1);
    chk("cpu reset", cpu_rst_n_o, 1'h0);
    chk("sys reset", sys_rst_n_o, 1'h1);
    chk("present", probe_present_flag, 1'h1);
    wr(`DBS_REG_STA, 8'h02);
    rd(`DBS_REG_STA);
    chk("refused", d, sta(1'h0, 1'h1, 1'h1, 1'h0));
    wr(`DBS_REG_STA, 8'h04);
    rd(`DBS_REG_STA);
    chk("zero write", d, sta(1'h0, 1'h1, 1'h0, 1'h0));
    // Locked and guarded triggers are dropped
    erase_lock_i <= 1'h1;
    wr(`DBS_REG_CTRL, 8'h01);
    chk("locked", vclr_rises, 32'h0);
    erase_lock_i <= 1'h0;
    guard_wp_i   <= 1'h1;
    wr(`DBS_REG_CTRL, 8'h01);
    chk("guarded", vclr_rises, 32'h0);
    guard_wp_i   <= 1'h0;
    // Acks stalled so a release lands mid-erase
    ack_en <= 1'h0;
    wr(`DBS_REG_CTRL, 8'h01);
    chk("vclr first", {vclr_req_o, flash_req_o}, 2'h2);
    wr(`DBS_REG_STA, 8'h02);
    rd(`DBS_REG_STA);
    chk("busy", d, sta(1'h0, 1'h1, 1'h0, 1'h1));
    ack_en <= 1'h1;
    for (int i = 0; i < 40 && d[0] !== 1'h1; i++)
      rd(`DBS_REG_STA);
    chk("done", d, sta(1'h1, 1'h1, 1'h0, 1'h0));
    chk("one erase", vclr_rises, 32'h1);
    chk("unprotected", prog_allow_o, 1'h1);
    wr(`DBS_REG_STA, 8'h02);
    chk("released", {cpu_reset_hold_flag, cpu_rst_n_o}, 2'h1);
    // Second power-on reset, then pad switched away
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (5) @(posedge hclk);
    chk("hp avail", hot_plug_available, 1'h1);
    pad_debug_i <= 1'h0;
    @(posedge hclk);
    pad_debug_i <= 1'h1;
    repeat (3) @(posedge hclk);
    rd(`DBS_REG_STB);
    chk("hp off", d, stb(1'h0, 1'h0));
    // Restart with clock high; frames then hot plug
    op(`DBS_ACT_RESTART, 2'h0, 8'h00);
    rd(`DBS_REG_STB);
    chk("hot plug", d, stb(1'h1, 1'h1));
    chk("no hold", {cpu_reset_hold_flag, cpu_rst_n_o}, 2'h1);
    print_verdict;
  end
endmodule
`default_nettype wire
